// >>> hdl/obd_pkg.sv
package obd_pkg;
    localparam logic [6:0] SMB_ADDR_DEF  = 7'h6c; // Arbitrary default.
    localparam logic [7:0] OFS_PIN_FN    = 8'h0a;
    localparam logic [7:0] OFS_AMP_ALT   = 8'h10;
    localparam logic [7:0] OFS_AMP_DEF   = 8'h11;
    localparam logic [7:0] OFS_STATUS    = 8'h12;
    localparam logic [7:0] OFS_IMP_LO    = 8'h14;
    localparam logic [7:0] OFS_IMP_HI    = 8'h15;
    localparam int         AMP_LSB       = 4;
    localparam int         PIN_FN_BIT    = 7;
    localparam int         SEEN_BIT      = 4;
    localparam int         KEEP_BIT      = 3;
    localparam int         SDTO_BIT      = 2;
    localparam int         LIVE_BIT      = 0;
    localparam logic [3:0] AMP_DEF_RST   = 4'h7;
    localparam logic [3:0] AMP_ALT_RST   = 4'hb;
    localparam logic       PIN_FN_RST    = 1'b0;
    localparam logic       KEEP_RST      = 1'b1;
    localparam logic       SDTO_RST      = 1'b1;
    localparam logic [7:0] IMP_LO_RST    = 8'h00;
    localparam logic [7:0] IMP_HI_RST    = 8'hff;
    localparam logic [9:0] SWING_BASE_MV = 10'h271;
    localparam logic [9:0] SWING_STEP_MV = 10'h019;
    localparam logic [9:0] SWING_RST_MV  = 10'h320;
    localparam logic [1:0] STRAP_LOW     = 2'h0;
    localparam logic [1:0] STRAP_MID     = 2'h1;
    localparam logic [1:0] STRAP_HIGH    = 2'h2;
    localparam logic [6:0] SYNC_RST      = 7'h0b;
    localparam logic [1:0] INIT_WAIT     = 2'h3;
    localparam int         CLK_MHZ       = 125;
    localparam int         TMO_MS        = 25;
    localparam int         TMO_CYC       = TMO_MS * CLK_MHZ * 1000;
    localparam int         TMO_W         = 22;

    typedef enum logic [1:0] {TERM_85, TERM_100, TERM_34} obd_term_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_A, ST_CMD, ST_ACK_C,
        ST_WDATA, ST_ACK_W, ST_RDATA, ST_MACK
    } obd_smb_st_t;

    typedef struct packed {
        logic [3:0] amp_def;
        logic [3:0] amp_alt;
        logic       pin_amp_sel;
        logic       keep;
        logic       sdto_en;
        logic [7:0] imp_lo;
        logic [7:0] imp_hi;
    } obd_cfg_t;

    typedef struct packed {
        logic [3:0] swing_code;
        logic [9:0] swing_mv;
    } obd_drive_t;
endpackage

// >>> hdl/obd_regs.sv
`timescale 1ns/100ps
module obd_regs #(
    parameter logic [6:0] SMB_ADDR   = obd_pkg::SMB_ADDR_DEF,
    parameter int         TMO_CYCLES = obd_pkg::TMO_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               smb_scl_i,
    input  wire logic               smb_sda_i,
    output logic                    smb_sda_o,
    output logic                    smb_sda_oe_o,
    input  wire logic               multifunction_pin_i,
    input  wire logic               power_good_powerdown_pin_i,
    input  wire logic [1:0]         impedance_strap_trilevel_i,
    input  wire logic               reference_input_clock_i,
    output obd_pkg::obd_drive_t     drive_o,
    output obd_pkg::obd_term_t      term_sel_o [8]
);
    import obd_pkg::*;

    logic [6:0]        pin_vec;
    logic [6:0]        sy1_ff, sy2_ff, sy3_ff, filt_ff, prev_ff, nxt_filt;
    logic              scl, sda, mf, pg, present;
    logic              scl_rise, scl_fall, start, stop, pg_fall, pg_rise;
    obd_smb_st_t       st_ff, nxt_st;
    logic [3:0]        bit_ff, nxt_bit;
    logic [7:0]        sh_ff, nxt_sh, tx_ff, nxt_tx, cmd_ff, nxt_cmd;
    logic              rw_ff, nxt_rw, wr_stb;
    logic [TMO_W-1:0]  scl_cnt_ff, nxt_scl_cnt, sda_cnt_ff, nxt_sda_cnt;
    logic              scl_tmo, sda_tmo;
    obd_cfg_t          cfg_ff, nxt_cfg, cfg_dflt;
    logic              seen_ff, nxt_seen, live_ff, nxt_live;
    logic              pend_ff, nxt_pend, init_ff, nxt_init;
    logic [1:0]        icnt_ff, nxt_icnt;
    logic [7:0]        s_lo_ff, nxt_s_lo, s_hi_ff, nxt_s_hi;
    logic [7:0]        rd_byte;
    obd_drive_t        drive_ff, nxt_drive;
    obd_term_t         term_ff [8];
    obd_term_t         nxt_term [8];

    assign pin_vec = {impedance_strap_trilevel_i, reference_input_clock_i,
                      power_good_powerdown_pin_i, multifunction_pin_i,
                      smb_sda_i, smb_scl_i};

    // Each pin passes three flops; a change counts once stages two and
    // three agree.
    for (genvar i = 0; i < 7; i++) begin : g_sync
        assign nxt_filt[i] = (sy2_ff[i] == sy3_ff[i]) ? sy2_ff[i] : filt_ff[i];
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sy1_ff  <= SYNC_RST;
            sy2_ff  <= SYNC_RST;
            sy3_ff  <= SYNC_RST;
            filt_ff <= SYNC_RST;
            prev_ff <= SYNC_RST;
        end else begin
            sy1_ff  <= pin_vec;
            sy2_ff  <= sy1_ff;
            sy3_ff  <= sy2_ff;
            filt_ff <= nxt_filt;
            prev_ff <= filt_ff;
        end
    end

    assign scl      = filt_ff[0];
    assign sda      = filt_ff[1];
    assign mf       = filt_ff[2];
    assign pg       = filt_ff[3];
    assign present  = filt_ff[4];
    assign scl_rise = scl & ~prev_ff[0];
    assign scl_fall = ~scl & prev_ff[0];
    assign start    = scl & prev_ff[0] & prev_ff[1] & ~sda;
    assign stop     = scl & prev_ff[0] & ~prev_ff[1] & sda;
    assign pg_fall  = ~pg & prev_ff[3];
    assign pg_rise  = pg & ~prev_ff[3];
    assign scl_tmo  = scl_cnt_ff == TMO_W'(TMO_CYCLES - 1);
    assign sda_tmo  = sda_cnt_ff == TMO_W'(TMO_CYCLES - 1);

    always_comb begin
        rd_byte = 8'h00;
        case (cmd_ff)
            OFS_PIN_FN:  rd_byte[PIN_FN_BIT] = cfg_ff.pin_amp_sel;
            OFS_AMP_ALT: rd_byte[7:AMP_LSB] = cfg_ff.amp_alt;
            OFS_AMP_DEF: rd_byte[7:AMP_LSB] = cfg_ff.amp_def;
            OFS_STATUS: begin
                rd_byte[SEEN_BIT] = seen_ff;
                rd_byte[KEEP_BIT] = cfg_ff.keep;
                rd_byte[SDTO_BIT] = cfg_ff.sdto_en;
                rd_byte[LIVE_BIT] = live_ff;
            end
            OFS_IMP_LO:  rd_byte = cfg_ff.imp_lo;
            OFS_IMP_HI:  rd_byte = cfg_ff.imp_hi;
            default:     rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        nxt_st  = st_ff;
        nxt_bit = bit_ff;
        nxt_sh  = sh_ff;
        nxt_tx  = tx_ff;
        nxt_cmd = cmd_ff;
        nxt_rw  = rw_ff;
        wr_stb  = 1'b0;
        nxt_scl_cnt = scl ? '0 : (scl_tmo ? scl_cnt_ff : scl_cnt_ff + 1'b1);
        nxt_sda_cnt = (sda || !cfg_ff.sdto_en) ? '0 :
                      (sda_tmo ? sda_cnt_ff : sda_cnt_ff + 1'b1);
        if (scl_tmo || (sda_tmo && cfg_ff.sdto_en) || stop) begin
            nxt_st = ST_IDLE;
        end else if (start) begin
            nxt_st  = ST_ADDR;
            nxt_bit = 4'h0;
        end else begin
            case (st_ff)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise) begin
                        nxt_sh  = {sh_ff[6:0], sda};
                        nxt_bit = bit_ff + 4'h1;
                    end else if (scl_fall && bit_ff == 4'h8) begin
                        nxt_bit = 4'h0;
                        if (st_ff == ST_ADDR) begin
                            nxt_rw = sh_ff[0];
                            nxt_st = (sh_ff[7:1] == SMB_ADDR) ? ST_ACK_A : ST_IDLE;
                        end else if (st_ff == ST_CMD) begin
                            nxt_cmd = sh_ff;
                            nxt_st  = ST_ACK_C;
                        end else begin
                            wr_stb = 1'b1;
                            nxt_st = ST_ACK_W;
                        end
                    end
                end
                ST_ACK_A: begin
                    if (scl_fall) begin
                        nxt_st = rw_ff ? ST_RDATA : ST_CMD;
                        nxt_tx = rd_byte;
                    end
                end
                ST_ACK_C, ST_ACK_W: begin
                    if (scl_fall) begin
                        nxt_st = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        nxt_bit = bit_ff + 4'h1;
                    end else if (scl_fall) begin
                        nxt_tx = {tx_ff[6:0], 1'b1};
                        if (bit_ff == 4'h8) begin
                            nxt_st  = ST_MACK;
                            nxt_bit = 4'h0;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        nxt_sh = {7'h00, sda};
                    end else if (scl_fall) begin
                        nxt_st = sh_ff[0] ? ST_IDLE : ST_RDATA;
                        nxt_tx = rd_byte;
                    end
                end
                default: nxt_st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff      <= ST_IDLE;
            bit_ff     <= 4'h0;
            sh_ff      <= 8'h00;
            tx_ff      <= 8'hff;
            cmd_ff     <= 8'h00;
            rw_ff      <= 1'b0;
            scl_cnt_ff <= '0;
            sda_cnt_ff <= '0;
        end else begin
            st_ff      <= nxt_st;
            bit_ff     <= nxt_bit;
            sh_ff      <= nxt_sh;
            tx_ff      <= nxt_tx;
            cmd_ff     <= nxt_cmd;
            rw_ff      <= nxt_rw;
            scl_cnt_ff <= nxt_scl_cnt;
            sda_cnt_ff <= nxt_sda_cnt;
        end
    end

    assign smb_sda_o    = 1'b0;
    assign smb_sda_oe_o = (st_ff == ST_ACK_A) || (st_ff == ST_ACK_C) ||
                          (st_ff == ST_ACK_W) || (st_ff == ST_RDATA && !tx_ff[7]);

    always_comb begin
        cfg_dflt = {AMP_DEF_RST, AMP_ALT_RST, PIN_FN_RST, KEEP_RST, SDTO_RST,
                    s_lo_ff, s_hi_ff};
        nxt_cfg  = cfg_ff;
        nxt_s_lo = s_lo_ff;
        nxt_s_hi = s_hi_ff;
        nxt_pend = pend_ff;
        nxt_init = init_ff;
        nxt_icnt = icnt_ff;
        nxt_seen = seen_ff | present;
        nxt_live = present;
        if (!init_ff) begin
            nxt_icnt = icnt_ff + 2'h1;
            if (icnt_ff == INIT_WAIT) begin
                nxt_init = 1'b1;
                nxt_s_lo = (nxt_filt[6:5] == STRAP_HIGH) ?
                           8'hff : 8'h00;
                nxt_s_hi = (nxt_filt[6:5] == STRAP_MID) ?
                           8'hff : 8'h00;
                nxt_cfg.imp_lo = nxt_s_lo;
                nxt_cfg.imp_hi = nxt_s_hi;
            end
        end else if (pg_fall && !cfg_ff.keep) begin
            nxt_cfg      = cfg_dflt;
            nxt_cfg.keep = 1'b0;
            nxt_pend     = 1'b1;
        end else if (pg_rise && pend_ff) begin
            nxt_cfg.keep = 1'b1;
            nxt_pend     = 1'b0;
        end else if (wr_stb) begin
            case (cmd_ff)
                OFS_PIN_FN:  nxt_cfg.pin_amp_sel = sh_ff[PIN_FN_BIT];
                OFS_AMP_ALT: nxt_cfg.amp_alt = sh_ff[7:AMP_LSB];
                OFS_AMP_DEF: nxt_cfg.amp_def = sh_ff[7:AMP_LSB];
                OFS_STATUS: begin
                    nxt_cfg.keep    = sh_ff[KEEP_BIT];
                    nxt_cfg.sdto_en = sh_ff[SDTO_BIT];
                end
                OFS_IMP_LO:  nxt_cfg.imp_lo = sh_ff;
                OFS_IMP_HI:  nxt_cfg.imp_hi = sh_ff;
                default:     nxt_cfg = cfg_ff;
            endcase
        end
        nxt_drive.swing_code = (cfg_ff.pin_amp_sel && mf) ? cfg_ff.amp_alt
                                                          : cfg_ff.amp_def;
        nxt_drive.swing_mv = SWING_BASE_MV +
                             SWING_STEP_MV * {6'h00, nxt_drive.swing_code};
    end

    for (genvar i = 0; i < 8; i++) begin : g_term
        assign nxt_term[i] = cfg_ff.imp_hi[i] ? TERM_34 :
                             (cfg_ff.imp_lo[i] ? TERM_100 : TERM_85);
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                term_ff[i] <= TERM_34;
            end else begin
                term_ff[i] <= nxt_term[i];
            end
        end
        assign term_sel_o[i] = term_ff[i];
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_ff   <= {AMP_DEF_RST, AMP_ALT_RST, PIN_FN_RST, KEEP_RST, SDTO_RST,
                         IMP_LO_RST, IMP_HI_RST};
            s_lo_ff  <= IMP_LO_RST;
            s_hi_ff  <= IMP_HI_RST;
            pend_ff  <= 1'b0;
            init_ff  <= 1'b0;
            icnt_ff  <= 2'h0;
            seen_ff  <= 1'b0;
            live_ff  <= 1'b0;
            drive_ff <= {AMP_DEF_RST, SWING_RST_MV};
        end else begin
            cfg_ff   <= nxt_cfg;
            s_lo_ff  <= nxt_s_lo;
            s_hi_ff  <= nxt_s_hi;
            pend_ff  <= nxt_pend;
            init_ff  <= nxt_init;
            icnt_ff  <= nxt_icnt;
            seen_ff  <= nxt_seen;
            live_ff  <= nxt_live;
            drive_ff <= nxt_drive;
        end
    end

    assign drive_o = drive_ff;

    a_swing_default: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !cfg_ff.pin_amp_sel |=> drive_ff.swing_code == $past(cfg_ff.amp_def))
        else $error("Default swing not applied.");
    a_swing_alt: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cfg_ff.pin_amp_sel && mf |=> drive_ff.swing_code == $past(cfg_ff.amp_alt))
        else $error("Alternate swing not applied.");
    a_swing_mv: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        drive_ff.swing_code == 4'hf |-> drive_ff.swing_mv == 10'h3e8)
        else $error("Swing code 15 is not 1000 mV.");
    a_seen_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        present |=> seen_ff ##1 seen_ff)
        else $error("Clock seen flag not sticky.");
    a_keep_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        init_ff && pg_fall && !cfg_ff.keep |=> cfg_ff.amp_def == AMP_DEF_RST)
        else $error("Configuration not cleared.");
    a_keep_return: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        init_ff && pend_ff && pg_rise && !pg_fall |=> cfg_ff.keep && !pend_ff)
        else $error("Keep bit did not return.");
    a_sda_timeout: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        sda_tmo && cfg_ff.sdto_en |=> st_ff == ST_IDLE)
        else $error("Data-line timeout did not release the bus.");
    a_scl_timeout: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        scl_tmo |=> st_ff == ST_IDLE && !smb_sda_oe_o)
        else $error("Clock-line timeout did not release the bus.");
    a_live_status: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        present ##1 present |-> live_ff)
        else $error("Live status does not follow the input.");
    a_term_high: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cfg_ff.imp_hi[0] |=> term_ff[0] == TERM_34)
        else $error("High termination bit did not override.");
endmodule

// >>> dv/obd_smb_host.sv
`timescale 1ns/100ps
module obd_smb_host (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    localparam int H = 8;

    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // One bit: data set while the clock is low, sampled late in the high.
    task automatic put_bit(input logic b, output logic r);
        sda_oe_o = ~b;
        tick(H);
        scl_o = 1'b1;
        tick(H);
        r = sda_i;
        scl_o = 1'b0;
        tick(2);
    endtask

    // Works from idle and as a repeated start.
    task automatic start_c();
        sda_oe_o = 1'b0;
        tick(H);
        scl_o = 1'b1;
        tick(H);
        sda_oe_o = 1'b1;
        tick(H);
        scl_o = 1'b0;
        tick(2);
    endtask

    task automatic stop_c();
        sda_oe_o = 1'b1;
        tick(H);
        scl_o = 1'b1;
        tick(H);
        sda_oe_o = 1'b0;
        tick(H);
    endtask

    // Ninth bit is released: device acknowledge, or host not-acknowledge.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
        put_bit(1'b1, a);
        ack = ~a;
    endtask

    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, dat,
                      output logic ack);
        logic [7:0] x;
        logic a0, a1, a2;
        start_c();
        xfer({dev, 1'b0}, x, a0);
        xfer(ofs, x, a1);
        xfer(dat, x, a2);
        stop_c();
        ack = a0 & a1 & a2;
    endtask

    task automatic rd(input logic [6:0] dev, input logic [7:0] ofs,
                      output logic [7:0] d, output logic ack);
        logic [7:0] x;
        logic a0, a1, a2, n;
        start_c();
        xfer({dev, 1'b0}, x, a0);
        xfer(ofs, x, a1);
        start_c();
        xfer({dev, 1'b1}, x, a2);
        xfer(8'hff, d, n);
        stop_c();
        ack = a0 & a1 & a2;
    endtask
endmodule

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
    import obd_pkg::*;
    localparam logic [6:0] ADDR = SMB_ADDR_DEF;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       mf = 1'b0;
    logic       pd = 1'b1;
    logic       ref_ck = 1'b0;
    logic [1:0] strap = STRAP_LOW;
    logic       scl;
    logic       host_oe;
    logic       sda_o;
    logic       dut_oe;
    logic       ack;
    logic       b;
    logic [7:0] rv;
    wire        sda = ~(host_oe | dut_oe);
    obd_drive_t drv;
    obd_term_t  term [8];
    int         errors = 0;
    int         n_tests = 0;

    always #4 clk = ~clk;

    obd_smb_host host_u (.clk_i(clk), .sda_i(sda), .scl_o(scl),
                         .sda_oe_o(host_oe));

    obd_regs #(.TMO_CYCLES(200)) dut_u (
        .clk_i(clk), .arst_n_i(arst_n), .smb_scl_i(scl), .smb_sda_i(sda),
        .smb_sda_o(sda_o), .smb_sda_oe_o(dut_oe), .multifunction_pin_i(mf),
        .power_good_powerdown_pin_i(pd), .impedance_strap_trilevel_i(strap),
        .reference_input_clock_i(ref_ck), .drive_o(drv), .term_sel_o(term));

    task automatic chk(input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic rst(input logic [1:0] s);
        arst_n = 1'b0;
        strap = s;
        wait_n(5);
        arst_n = 1'b1;
        wait_n(12);
    endtask

    task automatic rchk(input logic [7:0] ofs, exp);
        host_u.rd(ADDR, ofs, rv, ack);
        chk(16'(ack), 16'h1);
        chk(16'(rv), 16'(exp));
    endtask

    task automatic wreg(input logic [7:0] ofs, d);
        host_u.wr(ADDR, ofs, d, ack);
        chk(16'(ack), 16'h1);
    endtask

    task automatic terms(input logic [7:0] lo, hi);
        for (int i = 0; i < 8; i++)
            chk(16'(term[i]), hi[i] ? 16'(TERM_34) :
                lo[i] ? 16'(TERM_100) : 16'(TERM_85));
    endtask

    task automatic t_reset();
        rchk(OFS_AMP_DEF, 8'h70);
        rchk(OFS_STATUS, 8'h0c);
        rchk(OFS_IMP_LO, 8'h00);
        rchk(OFS_IMP_HI, 8'h00);
        chk(16'(drv.swing_mv), 16'd800);
        terms(8'h00, 8'h00);
        chk(16'(sda_o), 16'h0);
        rchk(8'h33, 8'h00);
        host_u.wr(ADDR ^ 7'h01, OFS_AMP_DEF, 8'h10, ack);
        chk(16'(ack), 16'h0);
        rchk(OFS_AMP_DEF, 8'h70);
    endtask

    task automatic t_amp();
        for (int c = 0; c < 16; c++) begin
            wreg(OFS_AMP_DEF, {4'(c), 4'h0});
            chk(16'(drv.swing_code), 16'(c));
            chk(16'(drv.swing_mv), 16'(625 + 25 * c));
        end
    endtask

    task automatic t_pin();
        wreg(OFS_AMP_DEF, 8'h20);
        mf = 1'b1;
        wait_n(10);
        chk(16'(drv.swing_mv), 16'd675);
        wreg(OFS_PIN_FN, 8'h80);
        chk(16'(drv.swing_mv), 16'd900);
        mf = 1'b0;
        wait_n(10);
        chk(16'(drv.swing_mv), 16'd675);
        wreg(OFS_PIN_FN, 8'h00);
    endtask

    task automatic t_term();
        wreg(OFS_IMP_LO, 8'ha5);
        terms(8'ha5, 8'h00);
        wreg(OFS_IMP_HI, 8'h81);
        terms(8'ha5, 8'h81);
        rchk(OFS_IMP_LO, 8'ha5);
    endtask

    task automatic t_status();
        ref_ck = 1'b1;
        wait_n(10);
        rchk(OFS_STATUS, 8'h1d);
        ref_ck = 1'b0;
        wait_n(10);
        rchk(OFS_STATUS, 8'h1c);
        wreg(OFS_STATUS, 8'h13);
        rchk(OFS_STATUS, 8'h10);
    endtask

    task automatic t_pd();
        wreg(OFS_AMP_DEF, 8'h30);
        pd = 1'b0;
        wait_n(10);
        rchk(OFS_STATUS, 8'h14);
        pd = 1'b1;
        wait_n(10);
        rchk(OFS_AMP_DEF, 8'h70);
        rchk(OFS_STATUS, 8'h1c);
        wreg(OFS_AMP_DEF, 8'h30);
        pd = 1'b0;
        wait_n(10);
        pd = 1'b1;
        wait_n(10);
        rchk(OFS_AMP_DEF, 8'h30);
    endtask

    task automatic t_tmo();
        host_u.start_c();
        for (int i = 6; i >= 0; i--) host_u.put_bit(ADDR[i], b);
        host_u.put_bit(1'b0, b);
        host_u.sda_oe_o = 1'b0;
        wait_n(6);
        chk(16'(dut_oe), 16'h1);
        wait_n(220);
        chk(16'(dut_oe), 16'h0);
        host_u.stop_c();
        rchk(OFS_AMP_DEF, 8'h30);
    endtask

    task automatic t_sdto(input logic en);
        wreg(OFS_STATUS, {4'h0, 1'b1, en, 2'h0});
        host_u.start_c();
        for (int i = 6; i >= 0; i--) host_u.put_bit(ADDR[i], b);
        host_u.put_bit(1'b0, b);
        host_u.sda_oe_o = 1'b0;
        wait_n(8);
        host_u.scl_o = 1'b1;
        wait_n(220);
        chk(16'(dut_oe), 16'(!en));
        host_u.scl_o = 1'b0;
        wait_n(2);
        host_u.stop_c();
        rchk(OFS_STATUS, {4'h1, 1'b1, en, 2'h0});
    endtask

    task automatic t_strap();
        rst(STRAP_MID);
        rchk(OFS_IMP_LO, 8'h00);
        rchk(OFS_IMP_HI, 8'hff);
        terms(8'h00, 8'hff);
        rst(STRAP_HIGH);
        rchk(OFS_IMP_LO, 8'hff);
        rchk(OFS_IMP_HI, 8'h00);
        terms(8'hff, 8'h00);
    endtask

    initial begin
        rst(STRAP_LOW);
        t_reset();
        t_amp();
        t_pin();
        t_term();
        t_status();
        t_pd();
        t_tmo();
        t_sdto(1'b0);
        t_sdto(1'b1);
        t_strap();
        tally_and_finish();
    end

    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule
